// ---- rtl/ssw_pkg.sv ----
`default_nettype none
package ssw_pkg;
   // timebase
   localparam int unsigned CLK_HZ           = 40000000;
   localparam int unsigned CLK_PERIOD_NS    = 25;
   // reset stretch after the last cause clears
   localparam int unsigned RST_TIMEOUT_MS   = 200;
   localparam int unsigned RST_TIMEOUT_CYC  = RST_TIMEOUT_MS * (CLK_HZ / 1000);
   // watchdog period, 1.6 s held in tenths
   localparam int unsigned WDOG_PERIOD_DS   = 16;
   localparam int unsigned WDOG_PERIOD_CYC  = WDOG_PERIOD_DS * (CLK_HZ / 10);
   // manual reset debounce, in microseconds
   localparam int unsigned DEBOUNCE_US      = 1000;
   localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_US * (CLK_HZ / 1000000);
   // variant encodings
   localparam logic [1:0]  VAR_DUAL_WP      = 2'h0;
   localparam logic [1:0]  VAR_LOW_ONLY     = 2'h1;
   localparam logic [1:0]  VAR_DUAL_KICK    = 2'h2;
   typedef enum logic [1:0] {
      ST_RESET   = 2'h0,
      ST_STRETCH = 2'h1,
      ST_RUN     = 2'h3
   } ssw_state_t;
endpackage
`default_nettype wire

// ---- rtl/ssw_debounce.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssw_debounce #(
   parameter int unsigned STABLE_CYC = 40000,
   parameter int unsigned CW         = 16
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // raw and filtered level
   input  wire logic din,
   output logic      dout
);
   logic [CW-1:0] cnt_q;
   logic          dout_q;

   // new level taken only after it holds for STABLE_CYC cycles
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q  <= '0;
         dout_q <= 1'b1;
      end
      else if (din == dout_q)
      begin
         cnt_q <= '0;
      end
      else if (cnt_q >= CW'(STABLE_CYC - 1))
      begin
         cnt_q  <= '0;
         dout_q <= din;
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
   assign dout = dout_q;
endmodule
`default_nettype wire

// ---- rtl/ssw_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssw_top #(
   parameter logic [1:0]  VARIANT     = ssw_pkg::VAR_DUAL_WP,
   parameter int unsigned TIMEOUT_CYC = ssw_pkg::RST_TIMEOUT_CYC,
   parameter int unsigned WDOG_CYC    = ssw_pkg::WDOG_PERIOD_CYC,
   parameter int unsigned DEBNC_CYC   = ssw_pkg::DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic resetn,
   // supply comparator
   input  wire logic supply_low,
   // manual reset and watchdog sources
   input  wire logic manual_reset_in_n,
   input  wire logic watchdog_kick_in,
   input  wire logic serial_data_in,
   // write protect and write gating
   input  wire logic write_protect,
   input  wire logic write_req,
   output logic      write_allow,
   // active-low reset pin, open drain
   input  wire logic reset_pin_n_in,
   output logic      reset_pin_n_out,
   output logic      reset_pin_n_oe,
   // active-high reset pin, driven high only while enabled, otherwise released
   output logic      reset_pin_hi_out,
   output logic      reset_pin_hi_oe
);
   localparam bit HAS_HI  = (VARIANT != ssw_pkg::VAR_LOW_ONLY);
   localparam bit HAS_WP  = (VARIANT == ssw_pkg::VAR_DUAL_WP);
   localparam bit HAS_KCK = (VARIANT == ssw_pkg::VAR_DUAL_KICK);

   // ==========================================================
   // reset release
   logic [1:0] rsync_q;
   logic       rst_n;
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rsync_q <= 2'h0;
      else
         rsync_q <= {rsync_q[0], 1'b1};
   end
   assign rst_n = rsync_q[1];

   // ==========================================================
   // manual reset debounce
   logic mr_clean;
   ssw_debounce #(
      .STABLE_CYC (DEBNC_CYC),
      .CW         (24)
   ) u_debounce (
      .clk   (core_clk),
      .rst_n (rst_n),
      .din   (manual_reset_in_n),
      .dout  (mr_clean)
   );

   // ==========================================================
   // watchdog
   logic        wd_src;
   logic        wd_prev_q;
   logic [31:0] wd_cnt_q;
   logic        wd_expired;
   logic        in_reset;
   assign wd_src = HAS_KCK ? watchdog_kick_in : serial_data_in;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         wd_prev_q <= 1'b0;
      else
         wd_prev_q <= wd_src;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         wd_cnt_q <= 32'h0;
      else if (in_reset || (wd_src != wd_prev_q))
         wd_cnt_q <= 32'h0;
      else if (!wd_expired)
         wd_cnt_q <= wd_cnt_q + 32'h1;
   end
   assign wd_expired = (wd_cnt_q >= 32'(WDOG_CYC));

   // ==========================================================
   // reset cause merge and stretch
   logic                ext_pin_low;
   logic                cause;
   logic [31:0]         st_cnt_q;
   ssw_pkg::ssw_state_t state_q;

   assign ext_pin_low = !reset_pin_n_in && !reset_pin_n_oe;
   assign cause = supply_low || !mr_clean || ext_pin_low || wd_expired;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q  <= ssw_pkg::ST_RESET;
         st_cnt_q <= 32'h0;
      end
      else if (cause)
      begin
         state_q  <= ssw_pkg::ST_RESET;
         st_cnt_q <= 32'h0;
      end
      else
      begin
         case (state_q)
            ssw_pkg::ST_RESET:
            begin
               state_q  <= ssw_pkg::ST_STRETCH;
               st_cnt_q <= 32'h1;
            end
            ssw_pkg::ST_STRETCH:
            begin
               if (st_cnt_q >= 32'(TIMEOUT_CYC))
                  state_q <= ssw_pkg::ST_RUN;
               else
                  st_cnt_q <= st_cnt_q + 32'h1;
            end
            ssw_pkg::ST_RUN:
               state_q <= ssw_pkg::ST_RUN;
            default:
               state_q <= ssw_pkg::ST_RESET;
         endcase
      end
   end
   assign in_reset = (state_q != ssw_pkg::ST_RUN);

   // ==========================================================
   // reset pins
   logic pin_q;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_q <= 1'b1;
      else
         pin_q <= in_reset;
   end
   assign reset_pin_n_out  = 1'b0;
   assign reset_pin_n_oe   = pin_q;
   // high output only in dual variants
   assign reset_pin_hi_out = 1'b1;
   assign reset_pin_hi_oe  = HAS_HI && pin_q;

   // ==========================================================
   // write gating
   logic ever_ok_q;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ever_ok_q <= 1'b0;
      else if (!supply_low)
         ever_ok_q <= 1'b1;
   end
   assign write_allow = write_req && ever_ok_q && !supply_low &&
                        !(HAS_WP && write_protect);

   // ==========================================================
   // checks
   // cause to pin takes two edges: state, then pin flop
   property p_supply;
      @(posedge core_clk) disable iff (!rst_n)
      supply_low |=> ##1 reset_pin_n_oe;
   endproperty
   a_supply : assert property (p_supply)
      else $error("supply low without reset");

   sequence s_release;
      !cause ##1 !cause;
   endsequence
   property p_hold;
      @(posedge core_clk) disable iff (!rst_n)
      ($fell(cause)) |-> ##1 reset_pin_n_oe;
   endproperty
   a_hold : assert property (p_hold)
      else $error("reset released without stretch");

   property p_stretch;
      @(posedge core_clk) disable iff (!rst_n)
      $fell(reset_pin_n_oe) |-> ($past(st_cnt_q) >= 32'(TIMEOUT_CYC));
   endproperty
   a_stretch : assert property (p_stretch)
      else $error("reset released before full timeout");

   property p_wp;
      @(posedge core_clk) disable iff (!rst_n)
      (HAS_WP && write_protect) |-> !write_allow;
   endproperty
   a_wp : assert property (p_wp)
      else $error("write allowed under protect");

   property p_lowsup;
      @(posedge core_clk) disable iff (!rst_n)
      supply_low |-> !write_allow;
   endproperty
   a_lowsup : assert property (p_lowsup)
      else $error("write allowed with supply low");

   property p_wd;
      @(posedge core_clk) disable iff (!rst_n)
      wd_expired |=> ##1 reset_pin_n_oe;
   endproperty
   a_wd : assert property (p_wd)
      else $error("watchdog expiry without reset");

   property p_mr;
      @(posedge core_clk) disable iff (!rst_n)
      !mr_clean |=> ##1 reset_pin_n_oe;
   endproperty
   a_mr : assert property (p_mr)
      else $error("manual reset not honoured");

   property p_reload;
      @(posedge core_clk) disable iff (!rst_n)
      (wd_src != wd_prev_q) |=> (wd_cnt_q == 32'h0);
   endproperty
   a_reload : assert property (p_reload)
      else $error("edge did not reload watchdog");

   property p_hi;
      @(posedge core_clk) disable iff (!rst_n)
      !HAS_HI |-> !reset_pin_hi_oe;
   endproperty
   a_hi : assert property (p_hi)
      else $error("high reset driven in low-only variant");

   property p_rel;
      @(posedge core_clk) disable iff (!rst_n)
      s_release ##0 (state_q == ssw_pkg::ST_RUN) |-> ##1 !reset_pin_n_oe;
   endproperty
   a_rel : assert property (p_rel)
      else $error("reset not released");
endmodule
`default_nettype wire

// ---- bench/ssw_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model (
   // pins from the supervisor
   input  wire logic pin_n_out,
   input  wire logic pin_n_oe,
   input  wire logic pin_hi_out,
   input  wire logic pin_hi_oe,
   // push-button pull on the low pin
   input  wire logic force_low,
   // resolved wire levels
   output logic      rst_n_wire,
   output logic      rst_hi_wire
);
   // ==========================================
   // wire resolution
   // pull-up on the low pin, pull-down on the high pin
   assign rst_n_wire  = !((pin_n_oe && !pin_n_out) || force_low);
   assign rst_hi_wire = pin_hi_oe && pin_hi_out;
endmodule
`default_nettype wire

// ---- bench/tb_ssw_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ssw_top;
   localparam int unsigned TO = 20;
   localparam int unsigned WD = 50;
   logic core_clk, resetn, supply_low, mr_n, wp, wreq, w_allow;
   logic pn_out, pn_oe, ph_out, ph_oe, force_low, rn_w, rh_w, kick_en;
   logic wdk_en, pk_oe, phk_oe, rn_k, pl_oe, phl_oe, rn_l, w_allow_l;
   logic sda = 1'h0;
   logic wdk = 1'h0;
   int   err_count, samples_checked, n;

   // ==========================================
   // design and host
   ssw_top #(.VARIANT(ssw_pkg::VAR_DUAL_WP), .TIMEOUT_CYC(TO),
             .WDOG_CYC(WD), .DEBNC_CYC(3)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .supply_low(supply_low),
      .manual_reset_in_n(mr_n), .watchdog_kick_in(wdk),
      .serial_data_in(sda), .write_protect(wp), .write_req(wreq),
      .write_allow(w_allow), .reset_pin_n_in(rn_w),
      .reset_pin_n_out(pn_out), .reset_pin_n_oe(pn_oe),
      .reset_pin_hi_out(ph_out), .reset_pin_hi_oe(ph_oe));
   ssw_host_model u_host (
      .pin_n_out(pn_out), .pin_n_oe(pn_oe), .pin_hi_out(ph_out),
      .pin_hi_oe(ph_oe), .force_low(force_low),
      .rst_n_wire(rn_w), .rst_hi_wire(rh_w));

   // kick-input and low-only variants, own pulls read back on the pin
   assign rn_k = !pk_oe;
   assign rn_l = !pl_oe;
   ssw_top #(.VARIANT(ssw_pkg::VAR_DUAL_KICK), .TIMEOUT_CYC(TO),
             .WDOG_CYC(WD), .DEBNC_CYC(3)) u_dut_kick (
      .core_clk(core_clk), .resetn(resetn), .supply_low(supply_low),
      .manual_reset_in_n(mr_n), .watchdog_kick_in(wdk),
      .serial_data_in(sda), .write_protect(wp), .write_req(wreq),
      .write_allow(), .reset_pin_n_in(rn_k),
      .reset_pin_n_out(), .reset_pin_n_oe(pk_oe),
      .reset_pin_hi_out(), .reset_pin_hi_oe(phk_oe));
   ssw_top #(.VARIANT(ssw_pkg::VAR_LOW_ONLY), .TIMEOUT_CYC(TO),
             .WDOG_CYC(WD), .DEBNC_CYC(3)) u_dut_low (
      .core_clk(core_clk), .resetn(resetn), .supply_low(supply_low),
      .manual_reset_in_n(mr_n), .watchdog_kick_in(wdk),
      .serial_data_in(sda), .write_protect(wp), .write_req(wreq),
      .write_allow(w_allow_l), .reset_pin_n_in(rn_l),
      .reset_pin_n_out(), .reset_pin_n_oe(pl_oe),
      .reset_pin_hi_out(), .reset_pin_hi_oe(phl_oe));

   initial
   begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end

   // serial activity keeps the watchdog fed
   always @(negedge core_clk)
      if (kick_en)
         sda <= ~sda;

   // partner toggles the kick input within the period
   always @(negedge core_clk)
      if (wdk_en)
         wdk <= ~wdk;

   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask

   // cycles until the chosen reset level shows, bounded
   task automatic wait_lvl(input logic kick, input logic lvl);
      logic seen;
      n = 0;
      seen = kick ? phk_oe : rh_w;
      while (seen !== lvl)
      begin
         cyc(1);
         n++;
         seen = kick ? phk_oe : rh_w;
         if (n > 300)
         begin
            err_count++;
            close_out;
         end
      end
   endtask

   // ==========================================
   // scenarios
   task automatic t_supply;
      supply_low = 1'h1;
      cyc(3);
      chk(rh_w, 1'h1);
      chk(rn_w, 1'h0);
      chk(pl_oe, 1'h1);
      chk(phl_oe, 1'h0);
      chk(w_allow, 1'h0);
      supply_low = 1'h0;
      wait_lvl(1'h0, 1'h0);
      chk(n >= TO && n <= TO + 6, 1'h1);
      chk(rn_w, 1'h1);
   endtask

   task automatic t_wp;
      cyc(1);
      chk(w_allow, 1'h1);
      wp = 1'h1;
      cyc(1);
      chk(w_allow, 1'h0);
      chk(w_allow_l, 1'h1);
      wp = 1'h0;
   endtask

   task automatic t_manual;
      // a glitch one cycle shorter than the filter must be ignored
      mr_n = 1'h0;
      cyc(2);
      mr_n = 1'h1;
      cyc(8);
      chk(rh_w, 1'h0);
      mr_n = 1'h0;
      cyc(10);
      chk(rn_w, 1'h0);
      mr_n = 1'h1;
      wait_lvl(1'h0, 1'h0);
      chk(n >= TO && n <= TO + 9, 1'h1);
   endtask

   task automatic t_ext;
      // own pull masks the pin, so the stretch runs from the pull start
      force_low = 1'h1;
      cyc(10);
      chk(rh_w, 1'h1);
      force_low = 1'h0;
      wait_lvl(1'h0, 1'h0);
      chk(n + 10 >= TO && n + 10 <= TO + 6, 1'h1);
   endtask

   task automatic t_wdog;
      cyc(WD + 20);
      chk(rh_w, 1'h0);
      kick_en = 1'h0;
      wait_lvl(1'h0, 1'h1);
      chk(n >= WD - 1 && n <= WD + 5, 1'h1);
      chk(phk_oe, 1'h0);
      kick_en = 1'h1;
      wait_lvl(1'h0, 1'h0);
      chk(n >= TO && n <= TO + 6, 1'h1);
   endtask

   task automatic t_kick;
      wdk_en = 1'h0;
      wait_lvl(1'h1, 1'h1);
      chk(n >= WD - 1 && n <= WD + 5, 1'h1);
      chk(rh_w, 1'h0);
      wdk_en = 1'h1;
      wait_lvl(1'h1, 1'h0);
      chk(n >= TO && n <= TO + 6, 1'h1);
   endtask

   initial
   begin
      err_count = 0;
      samples_checked = 0;
      resetn = 1'h0;
      supply_low = 1'h1;
      mr_n = 1'h1;
      wdk_en = 1'h1;
      wp = 1'h0;
      wreq = 1'h1;
      force_low = 1'h0;
      kick_en = 1'h1;
      cyc(5);
      resetn = 1'h1;
      t_supply;
      t_wp;
      t_manual;
      t_ext;
      t_wdog;
      t_kick;
      t_supply;
      close_out;
   end
endmodule
`default_nettype wire
